// File: core/ascii_formatter.sv
// Command interpreter and ASCII answer formatter for the gas sensor link
// Function
// - Period query CR LF answers period, space, five-digit multiplier, CR LF.
// - Multiplier follows range: 1 for 1%, 10 for 60%, 100 for 100%.
// - Temperature query answers tag, space, five digits; Celsius is (value-1000)/10.
// - Humidity query answers tag, space, five digits; percent is value/10.
// - Absent sensors give fixed 01000 temperature and 00000 humidity.
// - Each field is identifier, one space, five-digit decimal value.
// - Measurement string holds at most five fields chosen by the mask.
// - Weights: humidity 4096, temperature 64, filtered CO2 4, unfiltered CO2 2.
// - Diagnostic weights 2048, 1024, 256, 128, 32, 16 and 8.
// - Mask resets to 6; selector command echoes letter, space, padded mask.
// - Fields go out highest weight first, space separated, ended by CR LF.
`timescale 1ns/1ps
`include "fmt_params.svh"

module ascii_formatter (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire fmt_pkg::byte_t i_rx,
	output logic o_rx_ready,
	output fmt_pkg::byte_t o_tx,
	input wire logic i_tx_ready,
	input wire fmt_pkg::meas_t i_meas,
	input wire fmt_pkg::bus_req_t i_bus,
	output logic [31:0] o_rd_data
);

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [16:0] pow10(input logic [2:0] pos);
		logic [16:0] p;
		unique case (pos)
			3'h0: p = `POW_0;
			3'h1: p = `POW_1;
			3'h2: p = `POW_2;
			3'h3: p = `POW_3;
			default: p = `POW_4;
		endcase
		return p;
	endfunction

	function automatic logic [16:0] scale(input logic [1:0] range);
		logic [16:0] m;
		if (range == `RANGE_1PCT) begin
			m = `SCALE_1;
		end else if (range == `RANGE_60PCT) begin
			m = `SCALE_10;
		end else begin
			m = `SCALE_100;
		end
		return m;
	endfunction

	function automatic logic [16:0] temp_val(input fmt_pkg::meas_t m, input logic fit);
		return fit ? m.temp : `TEMP_ABSENT;
	endfunction

	function automatic logic [16:0] hum_val(input fmt_pkg::meas_t m, input logic fit);
		return fit ? m.hum : `HUM_ABSENT;
	endfunction

	// Highest pending weight goes first, which fixes the field order
	function automatic logic [3:0] top_field(input logic [12:0] pend);
		logic [3:0] idx;
		idx = 4'h0;
		for (int i = 0; i < 13; i++) begin
			if (pend[i]) begin
				idx = 4'(i);
			end
		end
		return idx;
	endfunction

	function automatic logic [7:0] field_tag(input logic [3:0] idx);
		logic [7:0] t;
		t = `CH_ZR;
		unique case (idx)
			4'(`FB_HUM): t = `CH_H;
			4'(`FB_FNORM): t = `CH_FD;
			4'(`FB_RNORM): t = `CH_RD;
			4'(`FB_ZPT): t = `CH_ZP;
			4'(`FB_RINV): t = `CH_RV;
			4'(`FB_TEMP): t = `CH_T;
			4'(`FB_FLED): t = `CH_LEDF;
			4'(`FB_RLED): t = `CH_LEDR;
			4'(`FB_FINV): t = `CH_FV;
			4'(`FB_ZF): t = `CH_ZF;
			default: t = `CH_ZR;
		endcase
		return t;
	endfunction

	function automatic logic [16:0] field_val(input logic [3:0] idx, input fmt_pkg::meas_t m,
		input logic tfit, input logic hfit);
		logic [16:0] v;
		v = m.co2_raw;
		unique case (idx)
			4'(`FB_HUM): v = hum_val(m, hfit);
			4'(`FB_FNORM): v = m.filt_norm;
			4'(`FB_RNORM): v = m.raw_norm;
			4'(`FB_ZPT): v = m.zero_pt;
			4'(`FB_RINV): v = m.raw_inv_temp;
			4'(`FB_TEMP): v = temp_val(m, tfit);
			4'(`FB_FLED): v = m.filt_led;
			4'(`FB_RLED): v = m.raw_led;
			4'(`FB_FINV): v = m.filt_inv_temp;
			4'(`FB_ZF): v = m.co2_filt;
			default: v = m.co2_raw;
		endcase
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State

	fmt_pkg::core_t s_ff;
	fmt_pkg::core_t nxt_s;
	logic can_send;
	logic [16:0] cur_pow;
	logic [3:0] fidx;
	logic [3:0] rx_digit;
	logic rx_is_digit;

	assign can_send = !s_ff.tx_v || i_tx_ready;
	assign cur_pow = pow10(s_ff.pos);
	assign fidx = top_field(s_ff.pend);
	assign rx_is_digit = (i_rx.data >= `CH_ZERO) && (i_rx.data <= `CH_NINE);
	assign rx_digit = 4'(i_rx.data - `CH_ZERO);

	// Input is held off while an answer is formed; no line buffer is kept
	assign o_rx_ready = (s_ff.st == fmt_pkg::ST_IDLE);
	assign o_tx.valid = s_ff.tx_v;
	assign o_tx.data = s_ff.tx_d;
	assign o_rd_data = s_ff.rdata;

	always_comb begin
		nxt_s = s_ff;
		nxt_s.tx_v = s_ff.tx_v && !i_tx_ready;
		unique case (s_ff.st)
			fmt_pkg::ST_IDLE: begin
				if (i_rx.valid) begin
					if (i_rx.data == `CH_CR) begin
						nxt_s.saw_cr = 1'b1;
					end else if (i_rx.data == `CH_LF && !s_ff.saw_cr) begin
						// A bare LF must not become the command letter
						nxt_s.saw_cr = 1'b0;
					end else if (i_rx.data == `CH_LF) begin
						nxt_s.saw_cr = 1'b0;
						nxt_s.have_cmd = 1'b0;
						nxt_s.have_arg = 1'b0;
						nxt_s.arg = 17'h00000;
						nxt_s.pend = 13'h0000;
						nxt_s.nfld = 3'h0;
						nxt_s.pos = 3'h0;
						nxt_s.dig = 4'h0;
						nxt_s.tag = s_ff.cmd;
						if (s_ff.have_cmd) begin
							unique case (s_ff.cmd)
								`CH_DOT: begin
									nxt_s.val = scale(s_ff.range);
									nxt_s.st = fmt_pkg::ST_TAG;
								end
								`CH_T: begin
									nxt_s.val = temp_val(i_meas, s_ff.t_fit);
									nxt_s.st = fmt_pkg::ST_TAG;
								end
								`CH_H: begin
									nxt_s.val = hum_val(i_meas, s_ff.h_fit);
									nxt_s.st = fmt_pkg::ST_TAG;
								end
								`CH_M: begin
									if (s_ff.have_arg) begin
										nxt_s.mask = s_ff.arg;
									end
									nxt_s.val = s_ff.have_arg ? s_ff.arg : s_ff.mask;
									nxt_s.st = fmt_pkg::ST_TAG;
								end
								`CH_Q: begin
									nxt_s.pend = s_ff.mask[12:0] & `FIELD_BITS;
									nxt_s.st = fmt_pkg::ST_SEP;
								end
								default: begin
									nxt_s.st = fmt_pkg::ST_IDLE;
								end
							endcase
						end
					end else begin
						nxt_s.saw_cr = 1'b0;
						if (!s_ff.have_cmd) begin
							nxt_s.cmd = i_rx.data;
							nxt_s.have_cmd = 1'b1;
						end else if (rx_is_digit) begin
							nxt_s.arg = 17'((s_ff.arg * `TEN) + {13'h0000, rx_digit});
							nxt_s.have_arg = 1'b1;
						end
					end
				end
			end
			fmt_pkg::ST_SEP: begin
				if (s_ff.pend != 13'h0000 && s_ff.nfld < `MAX_FIELDS) begin
					nxt_s.tag = field_tag(fidx);
					nxt_s.val = field_val(fidx, i_meas, s_ff.t_fit, s_ff.h_fit);
					nxt_s.pend[fidx] = 1'b0;
					nxt_s.nfld = s_ff.nfld + 3'h1;
					nxt_s.st = (s_ff.nfld != 3'h0) ? fmt_pkg::ST_GAP : fmt_pkg::ST_TAG;
				end else begin
					nxt_s.st = fmt_pkg::ST_CR;
				end
			end
			fmt_pkg::ST_GAP: begin
				if (can_send) begin
					nxt_s.tx_v = 1'b1;
					nxt_s.tx_d = `CH_SPACE;
					nxt_s.st = fmt_pkg::ST_TAG;
				end
			end
			fmt_pkg::ST_TAG: begin
				if (can_send) begin
					nxt_s.tx_v = 1'b1;
					nxt_s.tx_d = s_ff.tag;
					nxt_s.st = fmt_pkg::ST_SPACE;
				end
			end
			fmt_pkg::ST_SPACE: begin
				if (can_send) begin
					nxt_s.tx_v = 1'b1;
					nxt_s.tx_d = `CH_SPACE;
					nxt_s.st = fmt_pkg::ST_DIGIT;
				end
			end
			fmt_pkg::ST_DIGIT: begin
				// One subtraction a cycle keeps the divider out of the path
				if (s_ff.val >= cur_pow) begin
					nxt_s.val = s_ff.val - cur_pow;
					nxt_s.dig = s_ff.dig + 4'h1;
				end else if (can_send) begin
					nxt_s.tx_v = 1'b1;
					nxt_s.tx_d = `CH_ZERO + {4'h0, s_ff.dig};
					nxt_s.dig = 4'h0;
					if (s_ff.pos == `LAST_POS) begin
						nxt_s.pos = 3'h0;
						nxt_s.st = fmt_pkg::ST_SEP;
					end else begin
						nxt_s.pos = s_ff.pos + 3'h1;
					end
				end
			end
			fmt_pkg::ST_CR: begin
				if (can_send) begin
					nxt_s.tx_v = 1'b1;
					nxt_s.tx_d = `CH_CR;
					nxt_s.st = fmt_pkg::ST_LF;
				end
			end
			fmt_pkg::ST_LF: begin
				if (can_send) begin
					nxt_s.tx_v = 1'b1;
					nxt_s.tx_d = `CH_LF;
					nxt_s.resp_cnt = s_ff.resp_cnt + 16'h0001;
					nxt_s.st = fmt_pkg::ST_IDLE;
				end
			end
		endcase

		// Register port; a bus write beats a selector command in the same cycle
		nxt_s.rdata = 32'h00000000;
		if (i_bus.wr) begin
			if (i_bus.addr == `ADDR_CTRL) begin
				nxt_s.range = i_bus.wdata[`CTRL_RANGE_HI:`CTRL_RANGE_LO];
				nxt_s.t_fit = i_bus.wdata[`CTRL_TFIT];
				nxt_s.h_fit = i_bus.wdata[`CTRL_HFIT];
			end else if (i_bus.addr == `ADDR_MASK) begin
				nxt_s.mask = i_bus.wdata[16:0];
			end
		end
		if (i_bus.rd) begin
			if (i_bus.addr == `ADDR_CTRL) begin
				nxt_s.rdata[`CTRL_RANGE_HI:`CTRL_RANGE_LO] = s_ff.range;
				nxt_s.rdata[`CTRL_TFIT] = s_ff.t_fit;
				nxt_s.rdata[`CTRL_HFIT] = s_ff.h_fit;
			end else if (i_bus.addr == `ADDR_MASK) begin
				nxt_s.rdata[16:0] = s_ff.mask;
			end else if (i_bus.addr == `ADDR_STAT) begin
				nxt_s.rdata[`STAT_BUSY] = (s_ff.st != fmt_pkg::ST_IDLE);
				nxt_s.rdata[`STAT_TXV] = s_ff.tx_v;
				nxt_s.rdata[`STAT_PART] = s_ff.have_cmd;
				nxt_s.rdata[`STAT_CNT_HI:`STAT_CNT_LO] = s_ff.resp_cnt;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_ff <= '0;
			s_ff.st <= fmt_pkg::ST_IDLE;
			s_ff.mask <= `MASK_RST;
			s_ff.range <= `RANGE_RST;
			s_ff.t_fit <= `FIT_RST;
			s_ff.h_fit <= `FIT_RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

endmodule // ascii_formatter

// File: shared/fmt_params.svh
// Constants for the ASCII measurement formatter
`ifndef FMT_PARAMS_SVH
`define FMT_PARAMS_SVH
`define ADDR_CTRL 8'h00
`define ADDR_MASK 8'h04
`define ADDR_STAT 8'h08
`define CTRL_RANGE_LO 0
`define CTRL_RANGE_HI 1
`define CTRL_TFIT 2
`define CTRL_HFIT 3
`define STAT_BUSY 0
`define STAT_TXV 1
`define STAT_PART 2
`define STAT_CNT_LO 16
`define STAT_CNT_HI 31
`define RANGE_RST 2'h0
`define FIT_RST 1'b1
`define MASK_RST 17'h00006
`define FIELD_BITS 13'h1DFE
`define MAX_FIELDS 3'h5
`define LAST_POS 3'h4
`define RANGE_1PCT 2'h0
`define RANGE_60PCT 2'h1
`define SCALE_1 17'h00001
`define SCALE_10 17'h0000A
`define SCALE_100 17'h00064
`define TEMP_ABSENT 17'h003E8
`define HUM_ABSENT 17'h00000
`define POW_0 17'h02710
`define POW_1 17'h003E8
`define POW_2 17'h00064
`define POW_3 17'h0000A
`define POW_4 17'h00001
`define TEN 17'h0000A
`define CH_CR 8'h0D
`define CH_LF 8'h0A
`define CH_SPACE 8'h20
`define CH_ZERO 8'h30
`define CH_NINE 8'h39
`define CH_DOT 8'h2E
`define CH_T 8'h54
`define CH_H 8'h48
`define CH_M 8'h4D
`define CH_Q 8'h51
`define CH_FD 8'h64
`define CH_RD 8'h44
`define CH_ZP 8'h68
`define CH_RV 8'h56
`define CH_LEDF 8'h4F
`define CH_LEDR 8'h6F
`define CH_FV 8'h76
`define CH_ZF 8'h5A
`define CH_ZR 8'h7A
`define FB_HUM 12
`define FB_FNORM 11
`define FB_RNORM 10
`define FB_ZPT 8
`define FB_RINV 7
`define FB_TEMP 6
`define FB_FLED 5
`define FB_RLED 4
`define FB_FINV 3
`define FB_ZF 2
`define FB_ZR 1
`endif

// File: shared/fmt_pkg.sv
// Types shared by the ASCII measurement formatter
package fmt_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_TAG = 3'b001,
		ST_SPACE = 3'b010,
		ST_DIGIT = 3'b011,
		ST_SEP = 3'b100,
		ST_GAP = 3'b101,
		ST_CR = 3'b110,
		ST_LF = 3'b111
	} fmt_state_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} byte_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

	typedef struct packed {
		logic [16:0] hum;
		logic [16:0] filt_norm;
		logic [16:0] raw_norm;
		logic [16:0] zero_pt;
		logic [16:0] raw_inv_temp;
		logic [16:0] temp;
		logic [16:0] filt_led;
		logic [16:0] raw_led;
		logic [16:0] filt_inv_temp;
		logic [16:0] co2_filt;
		logic [16:0] co2_raw;
	} meas_t;

	typedef struct packed {
		fmt_state_t st;
		logic [7:0] cmd;
		logic [16:0] arg;
		logic have_cmd;
		logic have_arg;
		logic saw_cr;
		logic [16:0] mask;
		logic [1:0] range;
		logic t_fit;
		logic h_fit;
		logic [31:0] rdata;
		logic [12:0] pend;
		logic [2:0] nfld;
		logic [7:0] tag;
		logic [16:0] val;
		logic [2:0] pos;
		logic [3:0] dig;
		logic tx_v;
		logic [7:0] tx_d;
		logic [15:0] resp_cnt;
	} core_t;
endpackage

// File: tb/ascii_formatter_chk.sv
// Port assertions for the ASCII formatter
`timescale 1ns/1ps
`include "fmt_params.svh"
module ascii_formatter_chk (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire fmt_pkg::byte_t i_rx,
	input wire logic o_rx_ready,
	input wire fmt_pkg::byte_t o_tx,
	input wire logic i_tx_ready,
	input wire fmt_pkg::meas_t i_meas,
	input wire fmt_pkg::bus_req_t i_bus,
	input wire logic [31:0] o_rd_data
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	////////////////////////////////////////
	wire logic sent = o_tx.valid && i_tx_ready;
	wire logic dig = o_tx.data >= `CH_ZERO && o_tx.data <= `CH_NINE;
	logic [7:0] prev_ff;
	logic [2:0] ndig_ff;
	// Last accepted byte and the run of digits before it
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			prev_ff <= `CH_LF;
			ndig_ff <= 3'h0;
		end else if (sent) begin
			prev_ff <= o_tx.data;
			ndig_ff <= dig ? ndig_ff + 3'h1 : 3'h0;
		end
	end
	sequence s_take(logic [7:0] c);
		i_rx.valid && o_rx_ready && i_rx.data == c;
	endsequence
	sequence s_line(logic [7:0] c);
		s_take(c) ##1 s_take(`CH_CR) ##1 s_take(`CH_LF);
	endsequence
	sequence s_wr_mask;
		i_bus.wr && i_bus.addr == `ADDR_MASK;
	endsequence
	property p_mask_rb;
		s_wr_mask ##1 (i_bus.rd && i_bus.addr == `ADDR_MASK)
			|=> o_rd_data == {15'h0000, $past(i_bus.wdata[16:0], 2)};
	endproperty
	////////////////////////////////////////
	a_tx_stall_hold: assert property (o_tx.valid && !i_tx_ready
		|=> o_tx.valid && $stable(o_tx.data)) else $error("tx byte moved while stalled");
	a_ready_after_lf: assert property ($rose(o_rx_ready)
		|-> o_tx.valid && o_tx.data == `CH_LF) else $error("rx ready before final LF");
	a_lf_after_cr: assert property (sent && o_tx.data == `CH_LF
		|-> prev_ff == `CH_CR) else $error("LF not after CR");
	a_digit_after_space: assert property (sent && dig
		|-> prev_ff == `CH_SPACE || ndig_ff != 3'h0) else $error("digit without space");
	a_five_digits: assert property (sent && !dig && ndig_ff != 3'h0
		|-> ndig_ff == 3'h5) else $error("number not five digits");
	a_dot_answer: assert property (s_line(`CH_DOT)
		|-> ##[1:4] (o_tx.valid && o_tx.data == `CH_DOT)) else $error("no period answer");
	a_busy_no_rx: assert property (o_tx.valid && o_tx.data != `CH_LF
		|-> !o_rx_ready) else $error("rx ready while answering");
	a_mask_readback: assert property (p_mask_rb)
		else $error("mask read back wrong");
endmodule // ascii_formatter_chk

bind ascii_formatter ascii_formatter_chk u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_rx(i_rx),
	.o_rx_ready(o_rx_ready), .o_tx(o_tx), .i_tx_ready(i_tx_ready), .i_meas(i_meas),
	.i_bus(i_bus), .o_rd_data(o_rd_data));

// File: tb/host_model.sv
// Host side of the ASCII link: sends command lines, takes answers with stalls
`timescale 1ns/1ps
module host_model (
	input wire logic i_clk,
	input wire logic i_rx_ready,
	output fmt_pkg::byte_t o_rx,
	output logic o_tx_ready
);
	initial begin
		o_rx = '0;
		o_tx_ready = 1'b0;
	end
	// Random stalls, one cycle in four, so the formatter must hold stalled answer bytes
	always @(posedge i_clk) begin
		o_tx_ready <= ($urandom_range(0, 3) != 0);
	end
	// No concentration arguments are sent, so no scaling applies
	// Each char is held until taken; callers end lines with CR LF
	task automatic send(input string s);
		int n;
		for (int i = 0; i < s.len(); i++) begin
			o_rx <= '{valid: 1'b1, data: s[i]};
			n = 0;
			do begin
				@(posedge i_clk);
				n++;
			end while (!i_rx_ready && n < 4000);
			if (n >= 4000) begin
				tb.mismatches++;
				$display("[ERR] rx take expected ready seen timeout");
			end
		end
		// Released line shows the inverse so stale data cannot pass
		o_rx <= '{valid: 1'b0, data: ~o_rx.data};
	endtask
endmodule // host_model

// File: tb/tb.sv
// Self-checking bench for the ASCII formatter
`timescale 1ns/1ps
`include "fmt_params.svh"
module tb;
	logic i_clk;
	logic i_rst;
	logic rx_ready;
	logic tx_ready;
	logic rd_pend;
	logic [16:0] m;
	logic [31:0] rd_data;
	fmt_pkg::byte_t rx;
	fmt_pkg::byte_t tx;
	fmt_pkg::meas_t meas;
	fmt_pkg::bus_req_t bus;
	logic [7:0] txq[$];
	logic [31:0] rdq[$];
	logic [16:0] mv[11];
	int mismatches;
	int tests_run;
	// Field tags and mask bits, highest weight first
	localparam logic [7:0] TAGS[11] = '{`CH_H, `CH_FD, `CH_RD, `CH_ZP, `CH_RV, `CH_T,
		`CH_LEDF, `CH_LEDR, `CH_FV, `CH_ZF, `CH_ZR};
	localparam int BITS[11] = '{12, 11, 10, 8, 7, 6, 5, 4, 3, 2, 1};
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	ascii_formatter u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_rx(rx), .o_rx_ready(rx_ready),
		.o_tx(tx), .i_tx_ready(tx_ready), .i_meas(meas), .i_bus(bus), .o_rd_data(rd_data));
	host_model u_host (.i_clk(i_clk), .i_rx_ready(rx_ready), .o_rx(rx), .o_tx_ready(tx_ready));
	////////////////////////////////////////
	task automatic check8(input string what, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic check32(input string what, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask
	// Oldest note is compared whenever a result appears
	always @(posedge i_clk) begin
		if (rd_pend) check32("rd_data", rdq.pop_front(), rd_data);
		rd_pend <= bus.rd;
		if (tx.valid && tx_ready) check8("tx", txq.size() ? txq.pop_front() : 8'hXX, tx.data);
	end
	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	function automatic void exp_fld(input logic [7:0] tag, input int v);
		txq.push_back(tag);
		txq.push_back(`CH_SPACE);
		for (int p = 10000; p > 0; p /= 10) txq.push_back(8'(`CH_ZERO + (v / p) % 10));
	endfunction
	// A read carries its expected word in d
	task automatic bus_op(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
		if (r) rdq.push_back(d);
		bus <= '{addr: a, wdata: w ? d : 32'h0, wr: w, rd: r};
		@(posedge i_clk);
	endtask
	task automatic line(input string s);
		int n;
		u_host.send(s);
		n = 0;
		while ((txq.size() > 0 || !rx_ready) && n < 3000) begin
			@(posedge i_clk);
			n++;
		end
		if (n >= 3000) begin
			mismatches++;
			$display("[ERR] answer wait expected done seen timeout");
			wrap_up();
		end
		repeat (4) @(posedge i_clk);
	endtask
	task automatic ask(input string s, input logic [7:0] tag, input int v);
		exp_fld(tag, v);
		txq.push_back(`CH_CR);
		txq.push_back(`CH_LF);
		line(s);
	endtask
	task automatic new_meas();
		for (int i = 0; i < 11; i++) begin
			mv[i] = 17'($urandom_range(0, 99999));
			meas[186 - 17 * i -: 17] <= mv[i];
		end
	endtask
	// Fields in weight order, five at most, space between, CR LF at the end
	task automatic exp_q(input logic [16:0] mk);
		int k;
		k = 0;
		for (int i = 0; i < 11; i++) begin
			if (mk[BITS[i]] && k < 5) begin
				if (k > 0) txq.push_back(`CH_SPACE);
				exp_fld(TAGS[i], mv[i]);
				k++;
			end
		end
		txq.push_back(`CH_CR);
		txq.push_back(`CH_LF);
	endtask
	////////////////////////////////////////
	initial begin
		i_rst = 1'b1;
		bus = '0;
		meas = '0;
		rd_pend = 1'b0;
		mismatches = 0;
		tests_run = 0;
		void'($urandom(52835));
		repeat (12) @(posedge i_clk);
		i_rst <= 1'b0;
		bus_op(0, 1, `ADDR_CTRL, 32'h0000000C);
		bus_op(0, 1, `ADDR_MASK, 32'h00000006);
		bus_op(1, 0, 8'h0C, 32'hFFFFFFFF);
		bus_op(0, 1, 8'h0C, 32'h00000000);
		for (int r = 0; r < 4; r++) begin
			bus_op(1, 0, `ADDR_CTRL, 32'hC | r);
			bus_op(0, 0, 8'h00, 32'h0);
			ask(".\r\n", `CH_DOT, (r == 0) ? 1 : (r == 1) ? 10 : 100);
		end
		// Second pass has both sensors absent; stray LF must be ignored
		for (int f = 0; f < 2; f++) begin
			bus_op(1, 0, `ADDR_CTRL, f ? 32'h0 : 32'hC);
			bus_op(0, 0, 8'h00, 32'h0);
			new_meas();
			ask("T\n\r\n", `CH_T, f ? 1000 : mv[5]);
			ask("H\r\n", `CH_H, f ? 0 : mv[0]);
		end
		bus_op(1, 0, `ADDR_CTRL, 32'h0000000C);
		bus_op(0, 0, 8'h00, 32'h0);
		ask("M\r\n", `CH_M, 6);
		ask("M 4164\r\n", `CH_M, 4096 + 64 + 4);
		bus_op(0, 1, `ADDR_MASK, 32'h00001044);
		bus_op(0, 0, 8'h00, 32'h0);
		new_meas();
		exp_q(17'h01044);
		line("Q\r\n");
		line("W\r\n");
		line("\r\n");
		// All fields, ignored bits only, then random masks
		for (int i = 0; i < 8; i++) begin
			m = (i == 0) ? 17'h01DFE : (i == 1) ? 17'h00201 : 17'($urandom);
			bus_op(1, 0, `ADDR_MASK, {15'h0, m});
			bus_op(0, 1, `ADDR_MASK, {15'h0, m});
			bus_op(0, 0, 8'h00, 32'h0);
			new_meas();
			exp_q(m);
			line("Q\r\n");
		end
		// Nineteen answers so far, idle, no partial line
		bus_op(0, 1, `ADDR_STAT, 32'h00130000);
		bus_op(0, 0, 8'h00, 32'h0);
		bus_op(0, 0, 8'h00, 32'h0);
		wrap_up();
	end
endmodule // tb
